// ### src/rcs_run_stop_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module rcs_run_stop_ctrl
    import rcs_pkg::*;
#(
    parameter int unsigned DEV_BITS    = 8,
    parameter int unsigned CV_ENTRIES  = 4,
    parameter int unsigned CV_W        = 16,
    parameter int unsigned POT_RAW_W   = 10,
    parameter int unsigned FLASH_HALF  = FLASH_HALF_CYCLES,
    parameter logic [DEV_BITS-1:0] INPUT_CLASS = '0
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          panel_run_sw,
    input  wire logic [GEN_INPUTS-1:0]         general_inputs,
    input  wire logic                          run_terminal_enable,
    input  wire logic [3:0]                    run_terminal_sel,
    input  wire logic [1:0]                    unit_size,
    input  wire logic                          program_runstop_enable_flag,
    input  wire logic                          program_run_request_flag,
    input  wire logic                          program_stop_request_flag,
    input  wire logic                          remote_run_cmd,
    input  wire logic                          remote_stop_cmd,
    input  wire logic                          scan_tick,
    input  wire logic                          diag_done,
    input  wire logic                          diag_hw_ok,
    input  wire logic                          diag_param_ok,
    input  wire logic                          diag_prog_ok,
    input  wire logic                          op_req,
    input  wire logic [2:0]                    op_code,
    input  wire logic                          op_used_by_program,
    input  wire logic                          op_is_timer,
    input  wire logic [$clog2(DEV_BITS)-1:0]   op_bit,
    input  wire logic                          op_force_value,
    input  wire logic [$clog2(CV_ENTRIES)-1:0] op_cv_idx,
    input  wire logic [CV_W-1:0]               op_cv_data,
    input  wire logic                          cassette_in_use,
    input  wire logic                          cassette_protect,
    input  wire logic [DEV_BITS-1:0]           program_bits,
    input  wire logic [DEV_BITS-1:0]           terminal_bits,
    input  wire logic                          prog_cv_wr,
    input  wire logic [$clog2(CV_ENTRIES)-1:0] prog_cv_idx,
    input  wire logic [CV_W-1:0]               prog_cv_data,
    input  wire logic [POT_RAW_W-1:0]          pot_raw_one,
    input  wire logic [POT_RAW_W-1:0]          pot_raw_two,
    input  wire logic                          pot_raw_valid,
    output logic                               running,
    output logic                               run_led,
    output logic                               err_led,
    output logic                               op_ack,
    output logic                               op_ok,
    output logic [DEV_BITS-1:0]                device_bits,
    output logic [CV_ENTRIES*CV_W-1:0]         cur_values,
    output logic [7:0]                         pot_one_value_reg,
    output logic [7:0]                         pot_two_value_reg
);

    localparam int unsigned FW = $clog2(FLASH_HALF + 1);

    // All controller state except the pot readings held in u_pot sits in one register bank; its reset is the power-up.
    typedef struct packed {
        logic                          sw_meta;
        logic                          sw_sync;
        logic [GEN_INPUTS-1:0]         in_meta;
        logic [GEN_INPUTS-1:0]         in_sync;
        logic [DEV_BITS-1:0]           tb_meta;
        logic [DEV_BITS-1:0]           tb_sync;
        rcs_phase_e                    phase;
        rcs_remote_e                   remote;
        logic                          local_prev;
        logic                          prog_latch;
        logic                          pend_run;
        logic                          pend_stop;
        logic                          hw_fault;
        logic                          blink;
        logic [FW-1:0]                 blink_cnt;
        logic                          running;
        logic                          run_led;
        logic                          err_led;
        logic                          op_ack;
        logic                          op_ok;
        logic [DEV_BITS-1:0]           force_on;
        logic [DEV_BITS-1:0]           force_val;
        logic [DEV_BITS-1:0]           image;
        logic [CV_ENTRIES*CV_W-1:0]    cv;
    } rcs_state_s;

    rcs_state_s st_ff;
    rcs_state_s nxt_st;

    rcs_pot_if #(.RAW_W(POT_RAW_W)) pot_bus ();

    // Raw samples come from the on-chip converter on this clock, so no synchroniser.
    assign pot_bus.raw_one   = pot_raw_one;
    assign pot_bus.raw_two   = pot_raw_two;
    assign pot_bus.raw_valid = pot_raw_valid;

    rcs_pot_conv #(
        .RAW_W (POT_RAW_W)
    ) u_pot (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pot     (pot_bus.conv)
    );

    // Highest run terminal number allowed for the fitted unit size.
    logic [3:0] term_max;
    logic       term_level;
    logic       local_demand;

    always_comb begin
        case (unit_size)
            RCS_UNIT_14PT: term_max = TERM_MAX_14PT;
            RCS_UNIT_24PT: term_max = TERM_MAX_24PT;
            default:       term_max = TERM_MAX_FULL;
        endcase
    end

    // An out-of-range selection is ignored rather than wrapped onto another input.
    assign term_level = run_terminal_enable && (run_terminal_sel <= term_max)
                        && st_ff.in_sync[run_terminal_sel];

    // Local demand: switch, terminal, or program pushbutton latch.
    assign local_demand = st_ff.sw_sync
                          || term_level
                          || (program_runstop_enable_flag && st_ff.prog_latch);

    // Program-driven flag per image bit, taken from INPUT_CLASS: every non-input bit counts as driven.
    // Only non-input bits count, since input bits always reload from their terminals.
    logic [DEV_BITS-1:0] program_drive_mask;
    assign program_drive_mask = ~INPUT_CLASS;

    function automatic logic op_used_by_program_mask(input int idx);
        return program_drive_mask[idx];
    endfunction : op_used_by_program_mask

    // Next-state logic for the whole controller.
    always_comb begin
        logic cv_sel;
        logic allowed;
        logic is_run;
        logic [CV_W-1:0] cv_word;
        cv_sel  = 1'b0;
        allowed = 1'b0;
        is_run  = (st_ff.phase == RCS_PH_RUN);
        cv_word = '0;
        nxt_st  = st_ff;

        // Two flip-flops on the run switch, general inputs and terminal bits before anything reads them.
        nxt_st.sw_meta = panel_run_sw;
        nxt_st.sw_sync = st_ff.sw_meta;
        nxt_st.in_meta = general_inputs;
        nxt_st.in_sync = st_ff.in_meta;
        nxt_st.tb_meta = terminal_bits;
        nxt_st.tb_sync = st_ff.tb_meta;
        nxt_st.op_ack  = 1'b0;
        nxt_st.op_ok   = 1'b0;

        // Program pushbutton requests; stop wins when both arrive together.
        if (program_runstop_enable_flag) begin
            if (program_stop_request_flag) begin
                nxt_st.prog_latch = 1'b0;
            end else if (program_run_request_flag) begin
                nxt_st.prog_latch = 1'b1;
            end
        end

        // Remote commands wait for the next scan boundary; the later one replaces the earlier.
        if (remote_stop_cmd) begin
            nxt_st.pend_stop = 1'b1;
            nxt_st.pend_run  = 1'b0;
        end else if (remote_run_cmd) begin
            nxt_st.pend_run  = 1'b1;
            nxt_st.pend_stop = 1'b0;
        end

        // Blink timebase for a flashing error lamp.
        if (st_ff.blink_cnt == FW'(FLASH_HALF - 1)) begin
            nxt_st.blink_cnt = '0;
            nxt_st.blink     = ~st_ff.blink;
        end else begin
            nxt_st.blink_cnt = st_ff.blink_cnt + FW'(1);
        end

        case (st_ff.phase)
            RCS_PH_DIAG: begin
                // Power-on self check gates the first entry to the run decision.
                if (diag_done) begin
                    if (diag_hw_ok && diag_param_ok && diag_prog_ok) begin
                        nxt_st.phase = RCS_PH_STOP;
                    end else begin
                        nxt_st.phase    = RCS_PH_FAULT;
                        nxt_st.hw_fault = !diag_hw_ok;
                    end
                end
            end
            RCS_PH_FAULT: begin
                nxt_st.phase = RCS_PH_FAULT;
            end
            default: begin
                // Decision taken once per scan; a remote command overrides the local sources.
                if (scan_tick) begin
                    nxt_st.local_prev = local_demand;
                    nxt_st.pend_run   = 1'b0;
                    nxt_st.pend_stop  = 1'b0;
                    if (st_ff.pend_stop && !remote_stop_cmd && !remote_run_cmd) begin
                        nxt_st.remote = RCS_REM_STOP;
                    end else if (st_ff.pend_run && !remote_stop_cmd && !remote_run_cmd) begin
                        nxt_st.remote = RCS_REM_RUN;
                    end else if (local_demand && !st_ff.local_prev
                                 && st_ff.remote == RCS_REM_STOP) begin
                        nxt_st.remote = RCS_REM_NONE;
                    end
                    // A command landing this cycle is kept pending for the next scan instead of being cleared.
                    if (remote_stop_cmd || remote_run_cmd) begin
                        nxt_st.pend_run  = remote_run_cmd && !remote_stop_cmd;
                        nxt_st.pend_stop = remote_stop_cmd;
                    end
                    case (nxt_st.remote)
                        RCS_REM_RUN:  nxt_st.phase = RCS_PH_RUN;
                        RCS_REM_STOP: nxt_st.phase = RCS_PH_STOP;
                        default:      nxt_st.phase = local_demand ? RCS_PH_RUN
                                                                  : RCS_PH_STOP;
                    endcase
                end
            end
        endcase

        // The running port gets its own flop so it never hangs on a phase decode.
        nxt_st.running = (nxt_st.phase == RCS_PH_RUN);
        // Indicators follow the phase; a hardware fault lights steadily, others flash.
        nxt_st.run_led = (nxt_st.phase == RCS_PH_RUN);
        nxt_st.err_led = (nxt_st.phase == RCS_PH_FAULT)
                         && (nxt_st.hw_fault || nxt_st.blink);

        // Device image refresh at each scan boundary.
        if (scan_tick) begin
            for (int i = 0; i < DEV_BITS; i++) begin
                if (INPUT_CLASS[i]) begin
                    // Inputs always refresh, so a force on them lasts one scan at most.
                    nxt_st.image[i]    = st_ff.force_on[i] ? st_ff.force_val[i]
                                                           : st_ff.tb_sync[i];
                    nxt_st.force_on[i] = 1'b0;
                end else if (st_ff.force_on[i]) begin
                    // The forced level stands for this scan; the program then takes over.
                    nxt_st.image[i]    = st_ff.force_val[i];
                    nxt_st.force_on[i] = 1'b0;
                end else if (is_run && op_used_by_program_mask(i)) begin
                    nxt_st.image[i] = program_bits[i];
                end
            end
        end

        // Current values: program writes first, a same-cycle tool write lands last.
        if (prog_cv_wr) begin
            nxt_st.cv[prog_cv_idx*CV_W +: CV_W] = prog_cv_data;
        end

        // Tool operation permission check, answered the next cycle.
        if (op_req && st_ff.phase != RCS_PH_DIAG) begin
            case (op_code)
                RCS_OP_PARTIAL_PROG: allowed = 1'b1;
                RCS_OP_BATCH_PROG,
                RCS_OP_PARAM,
                RCS_OP_COMMENT,
                RCS_OP_FILEREG:      allowed = !is_run;
                RCS_OP_SETTING:      allowed = op_used_by_program
                                               && !(cassette_in_use
                                                    && cassette_protect);
                RCS_OP_CUR_VALUE:    allowed = 1'b1;
                RCS_OP_FORCE:        allowed = !(op_is_timer && op_force_value
                                                 && !op_used_by_program);
                default:             allowed = 1'b0;
            endcase
            nxt_st.op_ack = 1'b1;
            nxt_st.op_ok  = allowed;
            if (allowed && op_code == RCS_OP_CUR_VALUE) begin
                cv_sel  = 1'b1;
                cv_word = op_cv_data;
            end
            if (allowed && op_code == RCS_OP_FORCE) begin
                // Stopped or unused bits keep the forced level in the image itself.
                nxt_st.force_on[op_bit]  = is_run && op_used_by_program;
                nxt_st.force_val[op_bit] = op_force_value;
                nxt_st.image[op_bit]     = op_force_value;
            end
        end
        if (cv_sel) begin
            nxt_st.cv[op_cv_idx*CV_W +: CV_W] = cv_word;
        end
    end

    // Asynchronous reset is the power-up: remote override and forces are all discarded.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff        <= '0;
            st_ff.phase  <= RCS_PH_DIAG;
            st_ff.remote <= RCS_REM_NONE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from state flip-flops.
    assign running           = st_ff.running;
    assign run_led           = st_ff.run_led;
    assign err_led           = st_ff.err_led;
    assign op_ack            = st_ff.op_ack;
    assign op_ok             = st_ff.op_ok;
    assign device_bits       = st_ff.image;
    assign cur_values        = st_ff.cv;
    assign pot_one_value_reg = pot_bus.value_one;
    assign pot_two_value_reg = pot_bus.value_two;

endmodule : rcs_run_stop_ctrl

`default_nettype wire

// ### src/rcs_pkg.sv
package rcs_pkg;

    // Clock rate and the error indicator blink half period.
    localparam int unsigned CLK_MHZ           = 125;
    localparam int unsigned FLASH_HALF_MS     = 500;
    localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_MS * 1000 * CLK_MHZ;

    // Run terminal selection: highest usable input number per unit size.
    localparam logic [3:0] TERM_MAX_14PT = 4'h7;  // general_input_seven
    localparam logic [3:0] TERM_MAX_24PT = 4'hd;  // general_input_octal_fifteen
    localparam logic [3:0] TERM_MAX_FULL = 4'hf;  // general_input_octal_seventeen
    localparam int unsigned GEN_INPUTS   = 16;

    // Unit size codes.
    typedef enum logic [1:0] {
        RCS_UNIT_14PT = 2'b00,
        RCS_UNIT_24PT = 2'b01,
        RCS_UNIT_FULL = 2'b10
    } rcs_unit_e;

    // Operating phase of the controller.
    typedef enum logic [1:0] {
        RCS_PH_DIAG  = 2'b00,
        RCS_PH_STOP  = 2'b01,
        RCS_PH_RUN   = 2'b10,
        RCS_PH_FAULT = 2'b11
    } rcs_phase_e;

    // Remote override held from the programming tool.
    typedef enum logic [1:0] {
        RCS_REM_NONE = 2'b00,
        RCS_REM_RUN  = 2'b01,
        RCS_REM_STOP = 2'b10
    } rcs_remote_e;

    // Tool operations that are checked for permission.
    typedef enum logic [2:0] {
        RCS_OP_PARTIAL_PROG = 3'b000,
        RCS_OP_BATCH_PROG   = 3'b001,
        RCS_OP_PARAM        = 3'b010,
        RCS_OP_COMMENT      = 3'b011,
        RCS_OP_FILEREG      = 3'b100,
        RCS_OP_SETTING      = 3'b101,
        RCS_OP_CUR_VALUE    = 3'b110,
        RCS_OP_FORCE        = 3'b111
    } rcs_op_e;

    // Potentiometer reading width, taken from the top bits of each raw sample.
    localparam int unsigned POT_W = 8;

endpackage : rcs_pkg

// ### src/rcs_pot_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries raw converter samples in and the two readings out.
interface rcs_pot_if #(parameter int unsigned RAW_W = 10);
    logic [RAW_W-1:0] raw_one;
    logic [RAW_W-1:0] raw_two;
    logic             raw_valid;
    logic [7:0]       value_one;
    logic [7:0]       value_two;

    modport ctrl (output raw_one, output raw_two, output raw_valid,
                  input value_one, input value_two);
    modport conv (input raw_one, input raw_two, input raw_valid,
                  output value_one, output value_two);
endinterface : rcs_pot_if

`default_nettype wire

// ### src/rcs_pot_conv.sv
`timescale 1ns/1ps
`default_nettype none

// Scales two raw potentiometer samples to 0..255 readings and holds them.
module rcs_pot_conv
    import rcs_pkg::*;
#(
    parameter int unsigned RAW_W = 10
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    rcs_pot_if.conv   pot
);

    typedef struct packed {
        logic [POT_W-1:0] one;
        logic [POT_W-1:0] two;
    } rcs_pot_s;

    rcs_pot_s st_ff;
    rcs_pot_s nxt_st;

    // The converter counts up with clockwise rotation, so the top bits keep that sense.
    always_comb begin
        nxt_st = st_ff;
        if (pot.raw_valid) begin
            nxt_st.one = pot.raw_one[RAW_W-1 -: POT_W];
            nxt_st.two = pot.raw_two[RAW_W-1 -: POT_W];
        end
    end

    // Readings refresh on every valid sample so the program always sees the current knob.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pot.value_one = st_ff.one;
    assign pot.value_two = st_ff.two;

endmodule : rcs_pot_conv

`default_nettype wire

// ### verification/rcs_props_chk_properties.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the top ports only; all checks share one clock domain.
module rcs_props_chk #(
    parameter int unsigned POT_RAW_W = 10
) (
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic                 scan_tick,
    input wire logic                 running,
    input wire logic                 run_led,
    input wire logic                 err_led,
    input wire logic                 op_req,
    input wire logic [2:0]           op_code,
    input wire logic                 op_ack,
    input wire logic                 op_ok,
    input wire logic                 cassette_in_use,
    input wire logic                 cassette_protect,
    input wire logic                 remote_run_cmd,
    input wire logic                 remote_stop_cmd,
    input wire logic                 pot_raw_valid,
    input wire logic [POT_RAW_W-1:0] pot_raw_one,
    input wire logic [7:0]           pot_one_value_reg
);
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Tool operations are answered one cycle later, batch writes refused while running.
    op_answer_a: assert property (op_req && running |=> op_ack)
        else $error("tool operation not answered");
    batch_refused_a: assert property (op_req && running && op_code inside {3'h1, 3'h2, 3'h3, 3'h4}
        |=> op_ack && !op_ok) else $error("batch write accepted while running");
    partial_ok_a: assert property (op_req && running && op_code == 3'h0 |=> op_ok)
        else $error("partial edit refused while running");
    protect_refused_a: assert property (op_req && op_code == 3'h5 && cassette_in_use
        && cassette_protect |=> !(op_ack && op_ok)) else $error("setting change accepted");
    // The state may only move at a scan boundary, and a fault never runs.
    run_lamp_a: assert property (run_led == running)
        else $error("run lamp disagrees with state");
    scan_hold_a: assert property (!scan_tick |=> $stable(running))
        else $error("state moved between scans");
    fault_stop_a: assert property (err_led |-> !running)
        else $error("running with error lamp on");
    remote_stop_a: assert property (remote_stop_cmd && !remote_run_cmd && !scan_tick
        ##1 scan_tick |=> !running) else $error("remote stop ignored");
    pot_scale_a: assert property (pot_raw_valid |=>
        pot_one_value_reg == 8'($past(pot_raw_one) >> (POT_RAW_W - 8)))
        else $error("potentiometer reading wrong");
endmodule : rcs_props_chk

bind rcs_run_stop_ctrl rcs_props_chk #(.POT_RAW_W(POT_RAW_W)) i_rcs_props_chk (
    .ref_clk(ref_clk), .rst(rst), .scan_tick(scan_tick), .running(running),
    .run_led(run_led), .err_led(err_led), .op_req(op_req), .op_code(op_code),
    .op_ack(op_ack), .op_ok(op_ok), .cassette_in_use(cassette_in_use),
    .cassette_protect(cassette_protect), .remote_run_cmd(remote_run_cmd),
    .remote_stop_cmd(remote_stop_cmd), .pot_raw_valid(pot_raw_valid),
    .pot_raw_one(pot_raw_one), .pot_one_value_reg(pot_one_value_reg));

`default_nettype wire

// ### verification/rcs_field_model.sv
`timescale 1ns/1ps
`default_nettype none

// Scan sequencer and self check source standing beside the controller.
module rcs_field_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    output logic      scan_tick,
    output logic      diag_done,
    output logic      diag_ok
);
    logic [2:0] cnt_ff;

    // A short fixed scan of 8 cycles keeps bench waits brief; the result appears after one scan.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_ff    <= 3'h0;
            scan_tick <= 1'b0;
            diag_done <= 1'b0;
        end else begin
            cnt_ff    <= cnt_ff + 3'h1;
            scan_tick <= (cnt_ff == 3'h7);
            diag_done <= diag_done | (cnt_ff == 3'h7);
        end
    end

    // Parameters and program are always sound here; the hardware result comes from the bench.
    assign diag_ok = 1'b1;
endmodule : rcs_field_model

`default_nettype wire

// ### verification/test_run_stop_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none

module test_run_stop_mode_controller;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        sw      = 1'b0;
    logic [15:0] gi      = 16'h0;
    logic        te      = 1'b0;
    logic [3:0]  sel     = 4'h0;
    logic [1:0]  unit    = 2'h2;
    logic        pen     = 1'b0;
    logic        prq     = 1'b0;
    logic        psq     = 1'b0;
    logic        rr      = 1'b0;
    logic        rs      = 1'b0;
    logic        oreq    = 1'b0;
    logic [2:0]  ocode   = 3'h0;
    logic        oused   = 1'b0;
    logic        cas     = 1'b0;
    logic        prot    = 1'b0;
    logic [15:0] zz      = 16'h0;
    logic [9:0]  p1      = 10'h0;
    logic [9:0]  p2      = 10'h0;
    logic        pv      = 1'b0;
    logic        hw_ok   = 1'b1;
    logic        tmr     = 1'b0;
    logic        fv      = 1'b0;
    logic [15:0] cvd     = 16'h0;
    logic [7:0]  db;
    logic [63:0] cv;
    logic        tick, dd, dok, running, run_led, err_led, op_ack, op_ok;
    logic [7:0]  v1, v2;
    int          error_cnt = 0;
    int          tests_run = 0;

    always #4 ref_clk = ~ref_clk;

    rcs_field_model i_rcs_field_model (.ref_clk(ref_clk), .rst(rst),
        .scan_tick(tick), .diag_done(dd), .diag_ok(dok));

    rcs_run_stop_ctrl #(.FLASH_HALF(4)) i_rcs_run_stop_ctrl (.ref_clk(ref_clk), .rst(rst),
        .panel_run_sw(sw), .general_inputs(gi), .run_terminal_enable(te),
        .run_terminal_sel(sel), .unit_size(unit), .program_runstop_enable_flag(pen),
        .program_run_request_flag(prq), .program_stop_request_flag(psq),
        .remote_run_cmd(rr), .remote_stop_cmd(rs), .scan_tick(tick), .diag_done(dd),
        .diag_hw_ok(hw_ok), .diag_param_ok(dok), .diag_prog_ok(dok), .op_req(oreq),
        .op_code(ocode), .op_used_by_program(oused), .op_is_timer(tmr), .op_bit(3'h0),
        .op_force_value(fv), .op_cv_idx(zz[1:0]), .op_cv_data(cvd), .cassette_in_use(cas),
        .cassette_protect(prot), .program_bits(zz[7:0]), .terminal_bits(zz[7:0]),
        .prog_cv_wr(zz[0]), .prog_cv_idx(zz[1:0]), .prog_cv_data(zz), .pot_raw_one(p1),
        .pot_raw_two(p2), .pot_raw_valid(pv), .running(running), .run_led(run_led),
        .err_led(err_led), .op_ack(op_ack), .op_ok(op_ok), .device_bits(db), .cur_values(cv),
        .pot_one_value_reg(v1), .pot_two_value_reg(v2));

    task chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task give_verdict;
        $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Three scans cover the input synchronisers and a pending remote command.
    task settle;
        repeat (3) @(posedge ref_clk iff tick);
        @(posedge ref_clk);
    endtask : settle

    // The pulse lands in the cycle just before a scan boundary.
    task remote(input logic run);
        @(posedge ref_clk iff tick);
        repeat (6) @(posedge ref_clk);
        rr <= run;
        rs <= !run;
        @(posedge ref_clk);
        rr <= 1'b0;
        rs <= 1'b0;
    endtask : remote

    task op(input logic [2:0] c, input logic e);
        @(posedge ref_clk);
        ocode <= c;
        oreq  <= 1'b1;
        @(posedge ref_clk);
        oreq <= 1'b0;
        @(posedge ref_clk);
        chk(op_ack, 1'b1);
        chk(op_ok, e);
    endtask : op

    task rst_pulse;
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
    endtask : rst_pulse

    // Main sequence; each group ends with one report line.
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        sw  <= 1'b1;
        settle;
        chk(running, 1'b1);
        sw <= 1'b0;
        settle;
        chk(running, 1'b0);
        te   <= 1'b1;
        unit <= 2'h1;
        sel  <= 4'hd;
        gi   <= 16'h2000;
        settle;
        chk(running, 1'b1);
        sel <= 4'he;
        gi  <= 16'h4000;
        settle;
        chk(running, 1'b0);
        te <= 1'b0;
        $display("test run sources done");
        sw <= 1'b1;
        settle;
        remote(1'b0);
        settle;
        chk(running, 1'b0);
        remote(1'b1);
        settle;
        chk(running, 1'b1);
        remote(1'b0);
        settle;
        sw <= 1'b0;
        settle;
        sw <= 1'b1;
        settle;
        chk(running, 1'b1);
        $display("test remote done");
        for (int c = 0; c < 5; c++) op(3'(c), c == 0);
        cas   <= 1'b1;
        prot  <= 1'b1;
        oused <= 1'b1;
        op(3'h5, 1'b0);
        prot <= 1'b0;
        op(3'h5, 1'b1);
        sw <= 1'b0;
        settle;
        for (int c = 0; c < 5; c++) op(3'(c), 1'b1);
        tmr   <= 1'b1;
        fv    <= 1'b1;
        oused <= 1'b0;
        op(3'h7, 1'b0);
        oused <= 1'b1;
        op(3'h7, 1'b1);
        settle;
        chk(db, 8'h01);
        cvd <= 16'h5a5a;
        op(3'h6, 1'b1);
        chk(cv[15:0], 16'h5a5a);
        sw <= 1'b1;
        settle;
        op(3'h7, 1'b1);
        chk(db, 8'h01);
        settle;
        chk(db, 8'h00);
        sw <= 1'b0;
        $display("test tool ops done");
        pen <= 1'b1;
        prq <= 1'b1;
        settle;
        prq <= 1'b0;
        chk(running, 1'b1);
        psq <= 1'b1;
        settle;
        psq <= 1'b0;
        pen <= 1'b0;
        chk(running, 1'b0);
        @(posedge ref_clk);
        p1 <= 10'h3ff;
        p2 <= 10'h007;
        pv <= 1'b1;
        @(posedge ref_clk);
        pv <= 1'b0;
        @(posedge ref_clk);
        chk(v1, 8'hff);
        chk(v2, 8'h01);
        $display("test flags and pots done");
        remote(1'b1);
        settle;
        chk(running, 1'b1);
        rst_pulse;
        settle;
        chk(running, 1'b0);
        hw_ok <= 1'b0;
        rst_pulse;
        settle;
        chk(err_led, 1'b1);
        chk(running, 1'b0);
        $display("test power-up done");
        give_verdict;
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (8000) @(posedge ref_clk);
        error_cnt++;
        give_verdict;
    end
endmodule : test_run_stop_mode_controller

`default_nettype wire
